// ===== rtl/dirs_regs.vh
// Purpose: Register offsets, fields, reset values and timing counts.
// Assumes: 32-bit register words at byte addresses, 100 MHz ref_clk.
// Notes: Included by the route pair and input router design files, not by the two-entry buffer.
`ifndef DIRS_REGS_VH
`define DIRS_REGS_VH
`define DIRS_ADDR_W 8
`define DIRS_OFS_ROUTE 8'h00
`define DIRS_OFS_CTRL 8'h04
`define DIRS_OFS_STATUS 8'h08
`define DIRS_ROUTE_RST 16'h0000
`define DIRS_CTRL_RST 9'h000
`define DIRS_CTRL_AUTO 0
`define DIRS_CTRL_MANUAL 1
`define DIRS_CTRL_SRST_N 2
`define DIRS_CTRL_FSM_EN 3
`define DIRS_CTRL_FSM_TIME 4
`define DIRS_CTRL_DCK_FLIP 5
`define DIRS_CTRL_PWR_LSB 6
`define DIRS_CTRL_PWR_MSB 8
`define DIRS_ST_DETECT 0
`define DIRS_ST_RESETTING 1
`define DIRS_PCM_EXTRA 18
`define DIRS_FSM_DLY_LONG 264
`define DIRS_FSM_DLY_SHORT 136
`define DIRS_RST_FS 4
`define DIRS_PAT_A 16'h6969
`define DIRS_PAT_B 16'h5555
`define DIRS_PAT_C 16'h3333
`define DIRS_CONST_BITS 32
`define DIRS_TOGGLE_UNIT 16
`define DIRS_SAMPLE_W 24
`endif

// ===== rtl/dirs_route_pair.v
// Purpose: Source select and phase flip for one output pair.
// Assumes: Two's complement samples.
// Notes: Purely combinational; the caller registers the outputs.
`timescale 1ns/10ps
`include "dirs_regs.vh"
module dirs_route_pair (
    input wire [`DIRS_SAMPLE_W-1:0] in_left,
    input wire [`DIRS_SAMPLE_W-1:0] in_right,
    input wire single_source_sel,
    input wire source_swap_sel,
    input wire left_phase_flip,
    input wire right_phase_flip,
    output wire [`DIRS_SAMPLE_W-1:0] out_left,
    output wire [`DIRS_SAMPLE_W-1:0] out_right
);
    wire [`DIRS_SAMPLE_W-1:0] pick_left;
    wire [`DIRS_SAMPLE_W-1:0] pick_right;
    // see RULE1
    assign pick_left = source_swap_sel ? in_right : in_left;
    // see RULE2
    assign pick_right = single_source_sel ? pick_left :
                        (source_swap_sel ? in_left : in_right);
    // see RULE3
    assign out_left = left_phase_flip ? (~pick_left + 1'b1) : pick_left;
    assign out_right = right_phase_flip ? (~pick_right + 1'b1) :
                       pick_right;
endmodule // dirs_route_pair

// ===== rtl/dirs_skid2.v
// Purpose: Two-entry buffer with valid and ready on both sides.
// Assumes: Single clock domain.
// Notes: Ready toward the source is high while an entry is free.
`timescale 1ns/10ps
module dirs_skid2 #(
    parameter WIDTH = 8
) (
    input wire ref_clk,
    input wire arst_n,
    input wire flush,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:1];
    reg wr_ptr;
    reg rd_ptr;
    reg [1:0] count;
    wire push;
    wire pop;
    assign in_ready = (count != 2'd2);
    assign out_valid = (count != 2'd0);
    assign out_data = mem[rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count <= 2'd0;
            mem[0] <= {WIDTH{1'b0}};
            mem[1] <= {WIDTH{1'b0}};
        end else if (flush) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count <= 2'd0;
        end else begin
            if (push) begin
                mem[wr_ptr] <= in_data;
                wr_ptr <= ~wr_ptr;
            end
            if (pop) begin
                rd_ptr <= ~rd_ptr;
            end
            if (push && !pop) begin
                count <= count + 2'd1;
            end else if (pop && !push) begin
                count <= count - 2'd1;
            end
        end
    end
endmodule // dirs_skid2

// ===== rtl/dirs_input_route.v
// Purpose: Input routing and PCM/DSD format selection front end.
// Assumes: Serial pins are asynchronous to ref_clk and are synchronised.
// Notes: Sample words arrive already deserialised on a valid/ready port.
`timescale 1ns/10ps
`include "dirs_regs.vh"
//
// Function
// RULE1: Straight pass with swap zero; left and right exchanged with swap one.
// RULE2: Single source copies left input, or right input when swap is one.
// RULE3: Each output has its own negation after source selection.
// RULE4: Routing and flipping apply in both PCM and DSD formats.
// RULE5: Auto mode watches bit clock and frame pin to find format.
// RULE6: Detection runs only with power-down high, register mode, auto on.
// RULE7: Manual format bit used when auto off, ignored when auto on.
// RULE8: Software changes auto enable only while powered off or reset.
// RULE9: Software enables full-scale mute in auto mode, only when idle.
// RULE10: Auto mode adds 18 sample periods latency in PCM.
// RULE11: Full-scale mute in DSD adds 136 or 264 bit clocks latency.
// RULE12: Detected bit reads zero for PCM, one for DSD in auto mode.
// RULE13: Detected bit reads zero whenever auto mode is off.
// RULE14: No detection needed for phase modulation or flipped DSD edge.
// RULE15: Idle pattern twice gives DSD; 16n toggle or 32 constant gives PCM.
// RULE16: Detect only when idle, full-scale, powered off or reset; else keep.
// RULE17: Every format change resets the datapath for four sample periods.
// RULE18: Without register control, pairs route straight with no flip.
module dirs_input_route (
    input wire ref_clk,
    input wire arst_n,
    input wire power_down_n,
    input wire register_mode,
    input wire serial_bit_clock_pin,
    input wire frame_or_dsd_data_pin,
    input wire frame_strobe,
    input wire all_zero_idle,
    input wire all_fullscale,
    input wire [`DIRS_ADDR_W-1:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    input wire in_valid,
    output wire in_ready,
    input wire [8*`DIRS_SAMPLE_W-1:0] in_samples,
    output wire out_valid,
    input wire out_ready,
    output wire [8*`DIRS_SAMPLE_W-1:0] out_samples,
    output wire format_dsd,
    output wire datapath_reset
);
    localparam SW = `DIRS_SAMPLE_W;
    localparam DW = 8 * `DIRS_SAMPLE_W;
    localparam PAT_LEN = 7'd34;
    localparam ST_IDLE = 3'b001;
    localparam ST_SCAN = 3'b010;
    localparam ST_WAIT = 3'b100;

    reg [15:0] route_reg;
    reg [8:0] ctrl_reg;
    wire [3:0] single_source_sel;
    wire [3:0] source_swap_sel;
    wire [3:0] left_phase_flip;
    wire [3:0] right_phase_flip;
    wire auto_format_en;
    wire manual_format_sel;
    wire soft_reset_n;
    wire fullscale_mute_en;
    wire fullscale_detect_time_sel;
    wire dsd_clock_edge_flip;
    wire [2:0] channel_power;

    // Register access: writes take effect on the next clock edge, reads return next cycle.
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            route_reg <= `DIRS_ROUTE_RST;
            ctrl_reg <= `DIRS_CTRL_RST;
        end else if (reg_wr) begin
            if (reg_addr == `DIRS_OFS_ROUTE) begin
                route_reg <= reg_wdata[15:0];
            end
            if (reg_addr == `DIRS_OFS_CTRL) begin
                ctrl_reg <= reg_wdata[8:0];
            end
        end
    end

    // Pin control forces straight routing with no flips; see RULE18.
    assign single_source_sel = register_mode ? route_reg[3:0] : 4'h0;
    assign source_swap_sel = register_mode ? route_reg[7:4] : 4'h0;
    assign left_phase_flip = register_mode ? route_reg[11:8] : 4'h0;
    assign right_phase_flip = register_mode ? route_reg[15:12] : 4'h0;
    assign auto_format_en = ctrl_reg[`DIRS_CTRL_AUTO];
    assign manual_format_sel = ctrl_reg[`DIRS_CTRL_MANUAL];
    assign soft_reset_n = ctrl_reg[`DIRS_CTRL_SRST_N];
    assign fullscale_mute_en = ctrl_reg[`DIRS_CTRL_FSM_EN];
    assign fullscale_detect_time_sel = ctrl_reg[`DIRS_CTRL_FSM_TIME];
    assign dsd_clock_edge_flip = ctrl_reg[`DIRS_CTRL_DCK_FLIP];
    assign channel_power = ctrl_reg[`DIRS_CTRL_PWR_MSB:`DIRS_CTRL_PWR_LSB];

    // Two-stage synchronisers for the serial pins and power-down.
    reg [1:0] bck_sync;
    reg [1:0] frm_sync;
    reg [1:0] pdn_sync;
    reg bck_last;
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            bck_sync <= 2'b00;
            frm_sync <= 2'b00;
            pdn_sync <= 2'b00;
            bck_last <= 1'b0;
        end else begin
            bck_sync <= {bck_sync[0], serial_bit_clock_pin};
            frm_sync <= {frm_sync[0], frame_or_dsd_data_pin};
            pdn_sync <= {pdn_sync[0], power_down_n};
            bck_last <= bck_sync[1];
        end
    end
    wire bck_rise;
    assign bck_rise = bck_sync[1] && !bck_last;

    // Detection is permitted only in auto mode with power applied.
    wire detect_allowed;
    wire detect_start;
    assign detect_allowed = pdn_sync[1] && register_mode && auto_format_en &&
                            !dsd_clock_edge_flip; // see RULE6, RULE14
    assign detect_start = all_zero_idle || all_fullscale ||
                          (channel_power == 3'b000) || !soft_reset_n; // see RULE16

    // Pattern and toggle analyser, clocked by bit clock rising edges.
    reg [2:0] det_state;
    reg [31:0] shift;
    reg [6:0] bit_cnt;
    reg [5:0] run_len;
    reg [5:0] run_since;
    reg seen_dsd;
    reg seen_pcm;
    reg pend_valid;
    reg pend_dsd;
    reg auto_dsd;
    reg frm_last;
    wire [31:0] next_shift;
    wire pat_hit;
    wire toggled;
    assign next_shift = {shift[30:0], frm_sync[1]};
    assign pat_hit = (next_shift == {`DIRS_PAT_A, `DIRS_PAT_A}) ||
                     (next_shift == {`DIRS_PAT_B, `DIRS_PAT_B}) ||
                     (next_shift == {`DIRS_PAT_C, `DIRS_PAT_C});
    assign toggled = frm_sync[1] != shift[0];

    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            det_state <= ST_IDLE;
            shift <= 32'h00000000;
            bit_cnt <= 7'd0;
            run_len <= 6'd0;
            run_since <= 6'd0;
            seen_dsd <= 1'b0;
            seen_pcm <= 1'b0;
            pend_valid <= 1'b0;
            pend_dsd <= 1'b0;
            auto_dsd <= 1'b0;
            frm_last <= 1'b0;
        end else begin
            frm_last <= frm_sync[1];
            case (det_state)
                ST_IDLE: begin
                    bit_cnt <= 7'd0;
                    run_len <= 6'd0;
                    run_since <= 6'd0;
                    seen_dsd <= 1'b0;
                    seen_pcm <= 1'b0;
                    if (detect_allowed && detect_start) begin
                        det_state <= ST_SCAN; // see RULE5
                    end
                end
                ST_SCAN: begin
                    if (!detect_allowed) begin
                        det_state <= ST_IDLE;
                    end else if (bck_rise) begin
                        shift <= next_shift;
                        bit_cnt <= bit_cnt + 7'd1;
                        // A constant run or a toggle on a 16-bit grid is PCM.
                        if (toggled) begin
                            if (run_len[3:0] == 4'd0 && run_len != 6'd0) begin
                                run_since <= 6'd0;
                            end else begin
                                run_since <= 6'd63;
                            end
                            run_len <= 6'd1;
                        end else if (run_len != 6'd63) begin
                            run_len <= run_len + 6'd1;
                        end
                        if (pat_hit) begin
                            seen_dsd <= 1'b1; // see RULE15
                        end
                        if ((!toggled && run_len + 6'd1 >=
                             `DIRS_CONST_BITS) ||
                            (toggled && run_len != 6'd0 &&
                             run_len[3:0] == 4'd0 && run_since == 6'd0 &&
                             bit_cnt >= 7'd32)) begin
                            seen_pcm <= 1'b1; // see RULE15
                        end
                        if (bit_cnt + 7'd1 >= PAT_LEN) begin
                            det_state <= ST_WAIT;
                        end
                    end
                end
                ST_WAIT: begin
                    // The verdict lands on a rising edge of the frame pin.
                    if (!detect_allowed) begin
                        det_state <= ST_IDLE;
                    end else if (frm_sync[1] && !frm_last) begin
                        if (seen_dsd || seen_pcm) begin
                            pend_valid <= 1'b1;
                            pend_dsd <= seen_dsd;
                        end
                        det_state <= ST_IDLE;
                    end
                end
                default: begin
                    det_state <= ST_IDLE;
                end
            endcase
            if (pend_valid) begin
                auto_dsd <= pend_dsd;
                pend_valid <= 1'b0;
            end
        end
    end

    // Effective format: manual bit unless auto mode is on.
    assign format_dsd = auto_format_en ? auto_dsd : manual_format_sel; // see RULE7

    // Format change reset lasts the documented count of sample strobes.
    reg fmt_last;
    reg [2:0] rst_cnt;
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            fmt_last <= 1'b0;
            rst_cnt <= 3'd0;
        end else begin
            fmt_last <= format_dsd;
            if (fmt_last != format_dsd) begin
                rst_cnt <= 3'd`DIRS_RST_FS; // see RULE17
            end else if (frame_strobe && rst_cnt != 3'd0) begin
                rst_cnt <= rst_cnt - 3'd1;
            end
        end
    end
    assign datapath_reset = (rst_cnt != 3'd0);

    // Routing of the four pairs, identical in both formats.
    wire [DW-1:0] routed;
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_pair
            dirs_route_pair u_pair (
                .in_left(in_samples[(2*g)*SW +: SW]),
                .in_right(in_samples[(2*g+1)*SW +: SW]),
                .single_source_sel(single_source_sel[g]),
                .source_swap_sel(source_swap_sel[g]),
                .left_phase_flip(left_phase_flip[g]),
                .right_phase_flip(right_phase_flip[g]),
                .out_left(routed[(2*g)*SW +: SW]),
                .out_right(routed[(2*g+1)*SW +: SW])
            ); // see RULE4
        end
    endgenerate

    // Latency line: 18 frames in auto PCM, or the mute delay in DSD.
    reg [DW-1:0] dly_mem [0:511];
    reg [8:0] dly_wr;
    reg [8:0] dly_fill;
    reg [DW-1:0] stage_data;
    reg stage_valid;
    wire [8:0] dly_target;
    wire stage_ready;
    wire take;
    assign dly_target = (!format_dsd && auto_format_en) ? 9'd`DIRS_PCM_EXTRA :
        (format_dsd && fullscale_mute_en) ?
        (fullscale_detect_time_sel ? 9'd`DIRS_FSM_DLY_SHORT :
         9'd`DIRS_FSM_DLY_LONG) : 9'd0; // see RULE10, RULE11
    assign in_ready = !stage_valid || stage_ready;
    assign take = in_valid && in_ready && !datapath_reset;
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            dly_wr <= 9'd0;
            dly_fill <= 9'd0;
            stage_valid <= 1'b0;
            stage_data <= {DW{1'b0}};
        end else if (datapath_reset) begin
            dly_fill <= 9'd0;
            stage_valid <= 1'b0;
        end else begin
            if (stage_valid && stage_ready) begin
                stage_valid <= 1'b0;
            end
            if (take) begin
                dly_mem[dly_wr] <= routed;
                dly_wr <= dly_wr + 9'd1;
                if (dly_fill < dly_target) begin
                    dly_fill <= dly_fill + 9'd1;
                end else begin
                    stage_valid <= 1'b1;
                    stage_data <= (dly_target == 9'd0) ? routed :
                                  dly_mem[dly_wr - dly_target];
                end
            end
        end
    end

    dirs_skid2 #(
        .WIDTH(DW)
    ) u_buf (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .flush(datapath_reset),
        .in_valid(stage_valid),
        .in_ready(stage_ready),
        .in_data(stage_data),
        .out_valid(out_valid),
        .out_ready(out_ready),
        .out_data(out_samples)
    );

    // Read data one cycle after the read strobe.
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_rd) begin
            case (reg_addr)
                `DIRS_OFS_ROUTE: reg_rdata <= {16'h0000, route_reg};
                `DIRS_OFS_CTRL: reg_rdata <= {23'h000000, ctrl_reg};
                `DIRS_OFS_STATUS: reg_rdata <= {30'h00000000,
                    datapath_reset,
                    auto_format_en & auto_dsd}; // see RULE12, RULE13
                default: reg_rdata <= 32'h00000000;
            endcase
        end else begin
            reg_rdata <= 32'h00000000;
        end
    end
endmodule // dirs_input_route

// ===== dv/dirs_serial_src.sv
// Purpose: Serial source feeding the bit clock and frame or data pin.
// Assumes: Bit clock period 125 ns; data changes on the falling edge.
// Notes: Kind 0 sends a frame clock, kinds 1 to 3 send idle patterns.
`timescale 1ns/10ps
module dirs_serial_src (
    input wire run,
    input wire [1:0] kind,
    output logic serial_bit_clock_pin,
    output logic frame_or_dsd_data_pin
);
    logic [15:0] pat;
    logic [4:0] n;
    initial begin
        serial_bit_clock_pin = 1'b0;
        frame_or_dsd_data_pin = 1'b0;
        n = 5'h0;
        forever begin
            if (!run) begin
                // The clock stands still and the released line keeps moving.
                frame_or_dsd_data_pin = ~frame_or_dsd_data_pin;
                #125;
            end else begin
                pat = kind == 2'h1 ? 16'h6969 :
                    (kind == 2'h2 ? 16'h5555 : 16'h3333);
                frame_or_dsd_data_pin =
                    kind == 2'h0 ? n[4] : pat[~n[3:0]];
                #62.5;
                serial_bit_clock_pin = 1'b1;
                #62.5;
                serial_bit_clock_pin = 1'b0;
                n = n + 5'h1;
            end
        end
    end
endmodule // dirs_serial_src

// ===== dv/dirs_input_route_properties.sv
// Purpose: Port timing properties of the input router.
// Assumes: The control register is only changed through reg_wr.
// Notes: Auto and manual bits are shadowed from the write port.
`timescale 1ns/10ps
`include "dirs_regs.vh"
module dirs_input_route_properties (
    input wire ref_clk,
    input wire arst_n,
    input wire power_down_n,
    input wire [`DIRS_ADDR_W-1:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [31:0] reg_rdata,
    input wire out_valid,
    input wire out_ready,
    input wire [8*`DIRS_SAMPLE_W-1:0] out_samples,
    input wire frame_strobe,
    input wire format_dsd,
    input wire datapath_reset
);
    reg auto_sh;
    reg man_sh;
    reg [7:0] quiet;
    reg [2:0] fs_cnt;
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            auto_sh <= 1'b0;
            man_sh <= 1'b0;
            quiet <= 8'h00;
            fs_cnt <= 3'h0;
        end else begin
            if (reg_wr && reg_addr == `DIRS_OFS_CTRL) begin
                auto_sh <= reg_wdata[`DIRS_CTRL_AUTO];
                man_sh <= reg_wdata[`DIRS_CTRL_MANUAL];
                quiet <= 8'h00;
            end else if (quiet != 8'hff) begin
                quiet <= quiet + 8'h01;
            end
            if (!datapath_reset) begin
                fs_cnt <= 3'h0;
            end else if (frame_strobe && fs_cnt != 3'h7) begin
                fs_cnt <= fs_cnt + 3'h1;
            end
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    sequence s_off_rd;
        reg_rd && reg_addr == `DIRS_OFS_STATUS && !auto_sh;
    endsequence
    sequence s_on_rd;
        reg_rd && reg_addr == `DIRS_OFS_STATUS && auto_sh
            && $stable(format_dsd);
    endsequence
    a_rdata_idle:
        assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data not zero outside answer cycle");
    a_detect_off:
        assert property (s_off_rd |=> !reg_rdata[`DIRS_ST_DETECT])
        else $error("detected bit set with auto mode off");
    a_detect_on:
        assert property (s_on_rd |=>
            reg_rdata[`DIRS_ST_DETECT] == $past(format_dsd))
        else $error("detected bit differs from format");
    a_manual_fmt:
        assert property (!auto_sh && quiet == 8'hff |-> format_dsd == man_sh)
        else $error("format differs from manual bit");
    a_reset_follow:
        assert property ($changed(format_dsd) |-> ##[0:2] datapath_reset)
        else $error("no datapath reset after format change");
    a_reset_bound:
        assert property ($fell(datapath_reset) |->
            fs_cnt >= 3'h3 && fs_cnt <= 3'h4)
        else $error("datapath reset length wrong");
    a_out_hold:
        assert property (out_valid && !out_ready && !datapath_reset |=>
            out_valid && $stable(out_samples))
        else $error("output word changed while stalled");
    a_pd_hold:
        assert property (auto_sh && quiet == 8'hff && !power_down_n
            && $past(power_down_n, 3) == 1'b0 |-> $stable(format_dsd))
        else $error("format changed during power down");
endmodule // dirs_input_route_properties
bind dirs_input_route dirs_input_route_properties chk_u (.ref_clk,
    .arst_n, .power_down_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .out_valid, .out_ready, .out_samples, .frame_strobe,
    .format_dsd, .datapath_reset);

// ===== dv/dirs_input_route_bench.sv
// Purpose: Self-checking bench of the input router.
// Assumes: Route and format change only while the stream is empty.
// Notes: A queue of routed words predicts every output word.
`timescale 1ns/10ps
`include "dirs_regs.vh"
module dirs_input_route_bench;
    logic ref_clk, arst_n, power_down_n, register_mode, run, stall;
    logic all_zero_idle, all_fullscale, reg_wr, reg_rd, in_valid;
    logic out_ready = 1'b1;
    logic frame_strobe = 1'b0;
    logic [3:0] fcnt = 4'h0;
    logic [1:0] kind;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata;
    logic [15:0] route;
    logic [191:0] in_samples;
    logic [191:0] exp_q[$];
    wire [31:0] reg_rdata;
    wire [191:0] out_samples;
    wire in_ready, out_valid, format_dsd, datapath_reset;
    wire serial_bit_clock_pin, frame_or_dsd_data_pin;
    int num_errors, checks_done, n_out;
    dirs_input_route dut_u (.ref_clk, .arst_n, .power_down_n,
        .register_mode, .serial_bit_clock_pin, .frame_or_dsd_data_pin,
        .frame_strobe, .all_zero_idle, .all_fullscale, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .in_valid, .in_ready,
        .in_samples, .out_valid, .out_ready, .out_samples, .format_dsd,
        .datapath_reset);
    dirs_serial_src src_u (.run, .kind, .serial_bit_clock_pin,
        .frame_or_dsd_data_pin);
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    function automatic logic [191:0] route_word(input logic [191:0] w);
        logic [23:0] l, r, a, b;
        logic [3:0] c;
        route_word = w;
        for (int g = 0; g < 4; g++) begin
            l = w[48*g +: 24];
            r = w[48*g+24 +: 24];
            c = {route[g+12], route[g+8], route[g+4], route[g]};
            c = register_mode ? c : 4'h0;
            a = c[1] ? r : l;
            b = c[0] ? a : (c[1] ? l : r);
            route_word[48*g +: 24] = c[2] ? -a : a;
            route_word[48*g+24 +: 24] = c[3] ? -b : b;
        end
    endfunction
    task automatic check_val(input logic [31:0] g, e);
        checks_done++;
        if (g !== e) begin
            num_errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic check_word(input logic [191:0] g, e);
        checks_done++;
        if (g !== e) begin
            num_errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(posedge ref_clk) check_val(reg_rdata, e);
    endtask
    task automatic send(input int n);
        for (int i = 0; i < n; i++) begin
            in_samples <= {6{$urandom}};
            in_valid <= 1'b1;
            @(posedge ref_clk);
            while (!(in_ready && !datapath_reset)) @(posedge ref_clk);
        end
        in_valid <= 1'b0;
    endtask
    task automatic drain;
        for (int i = 0; i < 300 && exp_q.size() != 0; i++) @(posedge ref_clk);
        check_val(exp_q.size(), 32'h0);
    endtask
    task automatic wait_fmt(input logic e);
        for (int i = 0; i < 4000 && format_dsd !== e; i++) @(posedge ref_clk);
        check_val(format_dsd, e);
        repeat (4) @(posedge ref_clk);
        for (int i = 0; i < 300 && datapath_reset; i++) @(posedge ref_clk);
    endtask
    task report_and_stop;
        $display("checks=%0d errors=%0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        fcnt <= fcnt + 4'h1;
        frame_strobe <= &fcnt;
        out_ready <= stall ? 1'($urandom_range(1)) : 1'b1;
        if (arst_n && in_valid && in_ready && !datapath_reset)
            exp_q.push_back(route_word(in_samples));
        if (arst_n && out_valid && out_ready) begin
            n_out++;
            if (exp_q.size() == 0) check_val(32'h0, 32'h1);
            else check_word(out_samples, exp_q.pop_front());
        end
    end
    initial begin
        #800000;
        num_errors++;
        report_and_stop;
    end
    initial begin
        {arst_n, reg_wr, reg_rd, in_valid, run, stall, kind} = 0;
        {all_zero_idle, all_fullscale, reg_addr, reg_wdata} = 0;
        {route, in_samples} = 0;
        power_down_n = 1'b1;
        register_mode = 1'b1;
        {num_errors, checks_done, n_out} = 0;
        void'($urandom(69));
        repeat (20) @(posedge ref_clk);
        arst_n <= 1'b1;
        check_val({out_valid, in_ready}, 32'h1);
        rdchk(`DIRS_OFS_ROUTE, {16'h0, `DIRS_ROUTE_RST});
        rdchk(`DIRS_OFS_CTRL, {23'h0, `DIRS_CTRL_RST});
        rdchk(`DIRS_OFS_STATUS, 32'h0);
        rdchk(8'h0c, 32'h0);
        stall = 1'b1;
        for (int c = 0; c < 16; c++) begin
            for (int g = 0; g < 4; g++)
                {route[g+12], route[g+8], route[g+4], route[g]} = 4'(c + g);
            wr(`DIRS_OFS_ROUTE, {16'h0, route});
            rdchk(`DIRS_OFS_ROUTE, {16'h0, route});
            send(5);
            drain;
        end
        register_mode <= 1'b0;
        repeat (4) @(posedge ref_clk);
        send(8);
        drain;
        register_mode <= 1'b1;
        wr(`DIRS_OFS_CTRL, 32'h2);
        wait_fmt(1'b1);
        send(6);
        drain;
        rdchk(`DIRS_OFS_STATUS, 32'h0);
        wr(`DIRS_OFS_CTRL, 32'h0);
        wait_fmt(1'b0);
        wr(`DIRS_OFS_CTRL, 32'h0b);
        run <= 1'b1;
        for (int k = 1; k < 4; k++) begin
            kind <= 2'(k);
            wait_fmt(1'b1);
            rdchk(`DIRS_OFS_STATUS, 32'h1);
            kind <= 2'h0;
            wait_fmt(1'b0);
            rdchk(`DIRS_OFS_STATUS, 32'h0);
        end
        wr(`DIRS_OFS_CTRL, 32'h2b);
        kind <= 2'h1;
        repeat (1500) @(posedge ref_clk);
        check_val(format_dsd, 32'h0);
        power_down_n <= 1'b0;
        wr(`DIRS_OFS_CTRL, 32'h0b);
        repeat (1500) @(posedge ref_clk);
        check_val(format_dsd, 32'h0);
        power_down_n <= 1'b1;
        wait_fmt(1'b1);
        kind <= 2'h0;
        wait_fmt(1'b0);
        wr(`DIRS_OFS_CTRL, 32'h1cf);
        kind <= 2'h1;
        repeat (1500) @(posedge ref_clk);
        check_val(format_dsd, 32'h0);
        all_zero_idle <= 1'b1;
        wait_fmt(1'b1);
        {kind, all_zero_idle, all_fullscale} <= 4'h1;
        wait_fmt(1'b0);
        {run, all_fullscale, stall} <= 0;
        repeat (20) @(posedge ref_clk);
        n_out = 0;
        send(30);
        repeat (20) @(posedge ref_clk);
        check_val(n_out, 32'd12);
        report_and_stop;
    end
endmodule // dirs_input_route_bench
